// ### verilog/pwm_channel.sv
// Top of the PWM channel: AXI4-Lite register slave, period timer and
// duty compare. Assumes a single clock and an AXI4-Lite master that
// keeps at most one write and one read outstanding.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.

module pwm_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic pwm_output_pin
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] pend;
    logic [7:0] ctrl;
    logic [7:0] limit;
    logic [7:0] tcon;
    logic [7:0] tsel1;
    logic [7:0] tsel2;
  } bus_s;

  bus_s s_q, s_d;

  pwm_pkg::tmr_ctrl_s tctrl;
  pwm_pkg::tmr_out_s tout;
  pwm_pkg::byte_wr_s cnt_wr;
  pwm_pkg::byte_wr_s act_wr;
  pwm_pkg::reg_sel_e wr_sel;
  pwm_pkg::reg_sel_e rd_sel;
  logic [7:0] act_byte;
  logic [9:0] duty_pend;
  logic pwm_mode;
  logic force_low;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;
  logic wr_lane;
  logic [7:0] rd_byte;
  logic pin_out;

  //////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths

  function automatic pwm_pkg::reg_sel_e decode(logic [31:0] addr);
    unique case (addr)
      pwm_pkg::OFF_DUTY_PEND: return pwm_pkg::SEL_PEND;
      pwm_pkg::OFF_DUTY_ACT: return pwm_pkg::SEL_ACT;
      pwm_pkg::OFF_CTRL: return pwm_pkg::SEL_CTRL;
      pwm_pkg::OFF_CNT: return pwm_pkg::SEL_CNT;
      pwm_pkg::OFF_LIMIT: return pwm_pkg::SEL_LIMIT;
      pwm_pkg::OFF_TCON: return pwm_pkg::SEL_TCON;
      pwm_pkg::OFF_TSEL1: return pwm_pkg::SEL_TSEL1;
      pwm_pkg::OFF_TSEL2: return pwm_pkg::SEL_TSEL2;
      default: return pwm_pkg::SEL_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Derived controls

  // Ten-bit pending duty: high byte over the two control bits
  assign duty_pend = {s_q.pend, s_q.ctrl[pwm_pkg::CTRL_DUTY_LSB +: 2]};
  assign pwm_mode = s_q.ctrl[pwm_pkg::CTRL_MODE_LSB +: 2] == pwm_pkg::MODE_PWM;
  // Postscaler bits 6:3 are stored for software only
  assign tctrl.en = s_q.tcon[pwm_pkg::TCON_EN_BIT];
  assign tctrl.ps = s_q.tcon[pwm_pkg::TCON_PS_LSB +: 2];

  // Read mux: narrow registers in the low byte, zero above
  always_comb begin
    rd_sel = decode(araddr);
    unique case (rd_sel)
      pwm_pkg::SEL_PEND: rd_byte = s_q.pend;
      pwm_pkg::SEL_ACT: rd_byte = act_byte;
      pwm_pkg::SEL_CTRL: rd_byte = s_q.ctrl;
      pwm_pkg::SEL_CNT: rd_byte = tout.count;
      pwm_pkg::SEL_LIMIT: rd_byte = s_q.limit;
      pwm_pkg::SEL_TCON: rd_byte = s_q.tcon;
      pwm_pkg::SEL_TSEL1: rd_byte = s_q.tsel1;
      pwm_pkg::SEL_TSEL2: rd_byte = s_q.tsel2;
      default: rd_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and register file. Address and data are taken in either
  // order; the write is done once both are held, and the response is
  // withheld until then. Only one write and one read are in flight.

  always_comb begin
    s_d = s_q;
    cnt_wr = '0;
    act_wr = '0;
    force_low = 1'b0;
    aw_fire = awvalid && s_q.awready;
    w_fire = wvalid && s_q.wready;
    ar_fire = arvalid && s_q.arready;

    // Response retirement
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;

    // Capture address and data as they arrive
    if (aw_fire) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (w_fire) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end

    wr_do = s_d.aw_got && s_d.w_got && !s_q.bvalid;
    wr_sel = decode(s_d.awaddr);
    // Only the low lane carries register data; other lanes are ignored
    wr_lane = s_d.wstrb[0];

    if (wr_do) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wr_sel == pwm_pkg::SEL_NONE) ?
                  pwm_pkg::RESP_SLVERR : pwm_pkg::RESP_OKAY;
      if (wr_lane) begin
        unique case (wr_sel)
          pwm_pkg::SEL_PEND: s_d.pend = s_d.wdata[7:0];
          pwm_pkg::SEL_ACT: begin
            act_wr.wr = !pwm_mode;
            act_wr.data = s_d.wdata[7:0];
          end
          pwm_pkg::SEL_CTRL: begin
            // Top two bits are not implemented
            s_d.ctrl = s_d.wdata[7:0] & pwm_pkg::CTRL_MASK;
            force_low = s_d.ctrl == 8'h00;
          end
          pwm_pkg::SEL_CNT: begin
            cnt_wr.wr = 1'b1;
            cnt_wr.data = s_d.wdata[7:0];
          end
          pwm_pkg::SEL_LIMIT: s_d.limit = s_d.wdata[7:0];
          pwm_pkg::SEL_TCON: begin
            s_d.tcon = s_d.wdata[7:0] & pwm_pkg::TCON_MASK;
          end
          pwm_pkg::SEL_TSEL1: begin
            s_d.tsel1 = s_d.wdata[7:0] & pwm_pkg::TSEL1_MASK;
          end
          pwm_pkg::SEL_TSEL2: begin
            s_d.tsel2 = s_d.wdata[7:0] & pwm_pkg::TSEL2_MASK;
          end
          default: ;
        endcase
      end
    end

    // Read: one-cycle answer; unmapped reads give zero and SLVERR
    if (ar_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h000000, rd_byte};
      s_d.rresp = (rd_sel == pwm_pkg::SEL_NONE) ?
                  pwm_pkg::RESP_SLVERR : pwm_pkg::RESP_OKAY;
    end

    // Readies from flops; closed while a capture or answer is pending
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // Everything clears to zero: channel off, timer stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer and compare stages

  // Resolution is what the timer and its extra bits can step
  period_timer timer_u (
    .clk(clk),
    .rst(rst),
    .ctrl(tctrl),
    .limit(s_q.limit),
    .cnt_wr(cnt_wr),
    .tout(tout)
  );

  pwm_compare compare_u (
    .clk(clk),
    .rst(rst),
    .tin(tout),
    .duty_pend(duty_pend),
    .pwm_mode(pwm_mode),
    .force_low(force_low),
    .act_wr(act_wr),
    .act_byte(act_byte),
    .pin_out(pin_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Port drive, all from flops

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign arready = s_q.arready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign pwm_output_pin = pin_out;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  active_readonly_a: assert property (
    wr_do && wr_lane && wr_sel == pwm_pkg::SEL_ACT && pwm_mode &&
    !tout.restart |=> $stable(act_byte))
    else $error("active byte written in PWM mode");

  ctrl_top_zero_a: assert property (
    ar_fire && rd_sel == pwm_pkg::SEL_CTRL |=> rvalid && rdata[31:6] == 0)
    else $error("control read shows unimplemented bits");

  tcon_top_zero_a: assert property (
    ar_fire && rd_sel == pwm_pkg::SEL_TCON |=> rvalid && rdata[31:7] == 0)
    else $error("timer control read shows bit 7");

  reset_idle_a: assert property (
    $past(rst) |-> !pwm_output_pin && s_q.ctrl == 8'h00 &&
      tout.count == 8'h00 && act_byte == 8'h00)
    else $error("state not idle after reset");

  ctrl_clear_a: assert property (
    force_low |=> !pwm_output_pin ##1 !pwm_output_pin)
    else $error("output not forced low by control clear");

  write_resp_a: assert property (
    wr_do |=> bvalid && !awready && !wready)
    else $error("write response missing");

  read_resp_a: assert property (
    ar_fire |=> rvalid && !arready)
    else $error("read response missing");

  // Register writes land where the duty and period logic reads them
  pend_write_a: assert property (
    wr_do && wr_lane && wr_sel == pwm_pkg::SEL_PEND |=>
      duty_pend[9:2] == $past(s_d.wdata[7:0]))
    else $error("pending duty byte not written");

  duty_low_a: assert property (
    wr_do && wr_lane && wr_sel == pwm_pkg::SEL_CTRL |=>
      duty_pend[1:0] == $past(s_d.wdata[5:4]))
    else $error("duty low bits not taken from control");

  limit_write_a: assert property (
    wr_do && wr_lane && wr_sel == pwm_pkg::SEL_LIMIT |=>
      s_q.limit == $past(s_d.wdata[7:0]))
    else $error("period limit write lost");

  act_write_a: assert property (
    wr_do && wr_lane && wr_sel == pwm_pkg::SEL_ACT && !pwm_mode &&
    !tout.restart |=> act_byte == $past(s_d.wdata[7:0]))
    else $error("active byte write lost outside PWM mode");

  // A write without the low strobe must leave pend, ctrl, limit and tcon alone
  strobe_skip_a: assert property (
    wr_do && !wr_lane |=> $stable(s_q.pend) && $stable(s_q.ctrl) &&
      $stable(s_q.limit) && $stable(s_q.tcon))
    else $error("write without low strobe changed a register");

  unmapped_write_a: assert property (
    wr_do && wr_sel == pwm_pkg::SEL_NONE |=> bresp == pwm_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  unmapped_read_a: assert property (
    ar_fire && rd_sel == pwm_pkg::SEL_NONE |=>
      rresp == pwm_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");

  tsel_one_zero_a: assert property (
    ar_fire && rd_sel == pwm_pkg::SEL_TSEL1 |=>
      (rdata & ~{24'h000000, pwm_pkg::TSEL1_MASK}) == 32'h0)
    else $error("timer select one shows unimplemented bits");

  tsel_two_zero_a: assert property (
    ar_fire && rd_sel == pwm_pkg::SEL_TSEL2 |=>
      (rdata & ~{24'h000000, pwm_pkg::TSEL2_MASK}) == 32'h0)
    else $error("timer select two shows unimplemented bits");

  // Outside PWM mode the latch is held at its idle level
  mode_off_low_a: assert property (
    !pwm_mode |=> !pwm_output_pin)
    else $error("output high outside PWM mode");

endmodule // pwm_channel

// ### verilog/pwm_pkg.sv
// Shared constants and carrier types of the PWM duty-cycle channel.
// Assumes one 250 MHz clock domain and an AXI4-Lite register bus.
package pwm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CNT_W = 8;
  localparam int DUTY_W = 10;

  //////////////////////////////////////////////////////////////////////////
  // Byte addresses of the registers
  localparam logic [31:0] OFF_DUTY_PEND = 32'h0000_0000;
  localparam logic [31:0] OFF_DUTY_ACT = 32'h0000_0004;
  localparam logic [31:0] OFF_CTRL = 32'h0000_0008;
  localparam logic [31:0] OFF_CNT = 32'h0000_000c;
  localparam logic [31:0] OFF_LIMIT = 32'h0000_0010;
  localparam logic [31:0] OFF_TCON = 32'h0000_0014;
  localparam logic [31:0] OFF_TSEL1 = 32'h0000_0018;
  localparam logic [31:0] OFF_TSEL2 = 32'h0000_001c;

  //////////////////////////////////////////////////////////////////////////
  // Field positions, implemented-bit masks and reset values
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam int TCON_EN_BIT = 2;
  localparam int TCON_PS_LSB = 0;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] TCON_MASK = 8'h7f;
  localparam logic [7:0] TSEL1_MASK = 8'hd7;
  localparam logic [7:0] TSEL2_MASK = 8'h17;
  localparam logic [7:0] REG_RESET = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Timing: four clock phases per timer base step
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_PEND, SEL_ACT, SEL_CTRL, SEL_CNT, SEL_LIMIT, SEL_TCON,
    SEL_TSEL1, SEL_TSEL2, SEL_NONE
  } reg_sel_e;

  typedef struct packed {
    logic en;
    logic [1:0] ps;
  } tmr_ctrl_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [1:0] sub;
    logic restart;
  } tmr_out_s;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } byte_wr_s;

endpackage

// ### verilog/period_timer.sv
// Period timer: quarter-phase counter, 1/4/16 prescaler, 8-bit count.
// Assumes control and limit come from registers in the same domain.
module period_timer (
  input wire logic clk,
  input wire logic rst,
  input wire pwm_pkg::tmr_ctrl_s ctrl,
  input wire logic [7:0] limit,
  input wire pwm_pkg::byte_wr_s cnt_wr,
  output pwm_pkg::tmr_out_s tout
);

  typedef struct packed {
    logic [1:0] q;
    logic [3:0] pre;
    logic [7:0] count;
  } st_s;

  st_s s_q, s_d;
  logic tick;

  // Prescaler terminal decode for the selected ratio
  function automatic logic pre_done(logic [1:0] ps, logic [3:0] pre);
    if (ps == pwm_pkg::PS_1) return 1'b1;
    if (ps == pwm_pkg::PS_4) return pre[1:0] == pwm_pkg::PRE4_LAST;
    return pre == pwm_pkg::PRE16_LAST;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Timer step; a software write to the count also restarts the prescaler
  always_comb begin
    s_d = s_q;
    tick = (s_q.q == pwm_pkg::Q_LAST) && ctrl.en &&
           pre_done(ctrl.ps, s_q.pre);
    tout.restart = tick && (s_q.count == limit);
    s_d.q = 2'(s_q.q + 2'h1);
    if ((s_q.q == pwm_pkg::Q_LAST) && ctrl.en) begin
      s_d.pre = pre_done(ctrl.ps, s_q.pre) ? 4'h0 : 4'(s_q.pre + 4'h1);
    end
    if (cnt_wr.wr) begin
      s_d.count = cnt_wr.data;
      s_d.pre = 4'h0;
    end else if (tout.restart) begin
      s_d.count = 8'h00;
    end else if (tick) begin
      s_d.count = 8'(s_q.count + 8'h01);
    end
    // Two extra low bits: phase at 1:1, prescaler bits otherwise
    tout.count = s_q.count;
    if (ctrl.ps == pwm_pkg::PS_1) tout.sub = s_q.q;
    else if (ctrl.ps == pwm_pkg::PS_4) tout.sub = s_q.pre[1:0];
    else tout.sub = s_q.pre[3:2];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  prescale_ratio_a: assert property (
    tick && ctrl.ps[1] |-> s_q.pre == 4'hf && s_q.q == 2'h3)
    else $error("timer stepped before 16 prescaled phases");

endmodule // period_timer

// ### verilog/pwm_compare.sv
// Duty buffer and output latch: double-buffered 10-bit compare.
// Assumes restart and the extended count come from period_timer.
module pwm_compare (
  input wire logic clk,
  input wire logic rst,
  input wire pwm_pkg::tmr_out_s tin,
  input wire logic [9:0] duty_pend,
  input wire logic pwm_mode,
  input wire logic force_low,
  input wire pwm_pkg::byte_wr_s act_wr,
  output logic [7:0] act_byte,
  output logic pin_out
);

  typedef struct packed {
    logic [7:0] act;
    logic [1:0] lat;
    logic out;
  } st_s;

  st_s s_q, s_d;
  logic match;

  //////////////////////////////////////////////////////////////////////////
  // Buffer load at period end; clear on match, set at restart when the pending duty is nonzero
  always_comb begin
    s_d = s_q;
    match = {s_q.act, s_q.lat} == {tin.count, tin.sub};
    if (tin.restart) begin
      s_d.act = duty_pend[9:2];
      s_d.lat = duty_pend[1:0];
    end else if (act_wr.wr) begin
      s_d.act = act_wr.data;
    end
    // A duty above the period never matches, so the pin stays high
    if (force_low || !pwm_mode) s_d.out = 1'b0;
    else if (tin.restart) s_d.out = duty_pend != 10'h000;
    else if (match) s_d.out = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign act_byte = s_q.act;
  assign pin_out = s_q.out;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  match_clear_a: assert property (
    pwm_mode && !force_low && !tin.restart && match |=> !pin_out)
    else $error("output not cleared on duty match");

  period_load_a: assert property (
    tin.restart && pwm_mode && !force_low |=>
      {act_byte, s_q.lat} == $past(duty_pend) &&
      pin_out == ($past(duty_pend) != 10'h000))
    else $error("period restart did not load and set");

  zero_duty_a: assert property (
    tin.restart && duty_pend == 10'h000 |=> !pin_out)
    else $error("output set with zero duty");

  buffer_hold_a: assert property (
    !tin.restart && !act_wr.wr |=> $stable(s_q.lat) && $stable(act_byte))
    else $error("active duty changed mid period");

endmodule // pwm_compare

// ### tb/tb.sv
// Testbench of the PWM channel: AXI4-Lite register checks and pin
// waveform checks. Assumes the design sources under verilog/.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT_CYCLES = 12000;
  localparam logic [31:0] ADDR_T [6] = '{pwm_pkg::OFF_CTRL,
    pwm_pkg::OFF_TCON, pwm_pkg::OFF_TSEL1, pwm_pkg::OFF_TSEL2,
    pwm_pkg::OFF_CNT, pwm_pkg::OFF_LIMIT};
  localparam logic [31:0] MASK_T [6] = '{32'h3f, 32'h7f, 32'hd7,
    32'h17, 32'hff, 32'hff};

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] awaddr = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] wr_strobe = 4'hf;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] araddr = 32'h0;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic pwm_output_pin;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  pwm_channel pwm_channel_inst (.clk(clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pwm_output_pin(pwm_output_pin));

  ////////////////////////////////////////////////////////////////////////
  // Clock, and a guard so a stuck handshake cannot hang the run
  always #2 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT_CYCLES) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Closing report, the one place where the run ends
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Value comparison, four-state exact
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master: the first edge lets a previous release land first
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wr_strobe;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic ad;
    ad = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (!ad && arready === 1'b1) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    check_val({30'h0, r}, {30'h0, er});
  endtask

  task automatic check_reg(input logic [31:0] a, input logic [31:0] e,
                           input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(d, e);
    check_val({30'h0, r}, {30'h0, er});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Pin observers, sampled at rising edges and bounded
  task automatic wait_level(input logic v);
    int n;
    n = 0;
    while (pwm_output_pin !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // High time and period, from one rising edge of the pin to the next
  task automatic measure(output logic [31:0] hi, output logic [31:0] per);
    wait_level(1'b0);
    wait_level(1'b1);
    hi = 0;
    per = 0;
    while (pwm_output_pin === 1'b1 && per < 2000) begin
      hi++;
      per++;
      @(posedge clk);
    end
    while (pwm_output_pin !== 1'b1 && per < 2000) begin
      per++;
      @(posedge clk);
    end
  endtask

  task automatic count_high(input int n, output logic [31:0] hi);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      if (pwm_output_pin === 1'b1) hi++;
    end
  endtask

  // Skips the period in flight and the two after it, then checks the next one
  task automatic check_wave(input logic [31:0] ehi, input logic [31:0] eper);
    logic [31:0] hi;
    logic [31:0] per;
    measure(hi, per);
    measure(hi, per);
    check_val(hi, ehi);
    check_val(per, eper);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] w0;
    logic [31:0] hi;
    logic [31:0] per;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_val({31'h0, pwm_output_pin}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      check_reg(32'(i * 4), 32'h0, pwm_pkg::RESP_OKAY);
    end
    check_reg(32'h20, 32'h0, pwm_pkg::RESP_SLVERR);
    wr(32'h20, 32'h5, pwm_pkg::RESP_SLVERR);
    // Without the low strobe the write is ignored but answered OKAY
    wr_strobe = 4'he;
    wr(pwm_pkg::OFF_LIMIT, 32'h55, pwm_pkg::RESP_OKAY);
    wr_strobe = 4'hf;
    check_reg(pwm_pkg::OFF_LIMIT, 32'h0, pwm_pkg::RESP_OKAY);
    $display("test reset_values done");

    // Timer control is cleared before the count is written, so it holds
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_T[i], 32'hffff_ffff, pwm_pkg::RESP_OKAY);
      check_reg(ADDR_T[i], MASK_T[i], pwm_pkg::RESP_OKAY);
      wr(ADDR_T[i], 32'h0, pwm_pkg::RESP_OKAY);
    end
    $display("test masks done");

    wr(pwm_pkg::OFF_DUTY_ACT, 32'h5a, pwm_pkg::RESP_OKAY);
    check_reg(pwm_pkg::OFF_DUTY_ACT, 32'h5a, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h0c, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_DUTY_ACT, 32'h11, pwm_pkg::RESP_OKAY);
    check_reg(pwm_pkg::OFF_DUTY_ACT, 32'h5a, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h0, pwm_pkg::RESP_OKAY);
    $display("test active_read_only done");

    // Period first, duty next, timer then, PWM mode last
    wr(pwm_pkg::OFF_LIMIT, 32'h3, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_DUTY_PEND, 32'h1, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h20, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_TCON, 32'h04, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h2c, pwm_pkg::RESP_OKAY);
    measure(w0, per);
    measure(w0, per);
    check_val(per, 32'd16);
    // Duty 6: set at restart, cleared the edge after the match
    check_val(w0, 32'd7);
    wr(pwm_pkg::OFF_CTRL, 32'h3c, pwm_pkg::RESP_OKAY);
    check_wave(32'd8, 32'd16);
    // New pending byte lands while the pin is high: width must hold
    wait_level(1'b0);
    wait_level(1'b1);
    fork
      begin
        hi = 0;
        while (pwm_output_pin === 1'b1 && hi < 100) begin
          hi++;
          @(posedge clk);
        end
      end
      wr(pwm_pkg::OFF_DUTY_PEND, 32'h2, pwm_pkg::RESP_OKAY);
    join
    check_val(hi, 32'd8);
    check_wave(32'd12, 32'd16);
    check_reg(pwm_pkg::OFF_DUTY_ACT, 32'h2, pwm_pkg::RESP_OKAY);
    $display("test duty_buffer done");

    wr(pwm_pkg::OFF_TCON, 32'h05, pwm_pkg::RESP_OKAY);
    measure(hi, per);
    measure(hi, per);
    check_val(per, 32'd64);
    wr(pwm_pkg::OFF_TCON, 32'h06, pwm_pkg::RESP_OKAY);
    measure(hi, per);
    measure(hi, per);
    check_val(per, 32'd256);
    wr(pwm_pkg::OFF_TCON, 32'h7c, pwm_pkg::RESP_OKAY);
    check_wave(32'd12, 32'd16);
    $display("test prescale done");

    wr(pwm_pkg::OFF_DUTY_PEND, 32'hff, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h3c, pwm_pkg::RESP_OKAY);
    repeat (40) @(posedge clk);
    count_high(48, hi);
    check_val(hi, 32'd48);
    wr(pwm_pkg::OFF_DUTY_PEND, 32'h0, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h0c, pwm_pkg::RESP_OKAY);
    repeat (40) @(posedge clk);
    count_high(48, hi);
    check_val(hi, 32'd0);
    wr(pwm_pkg::OFF_DUTY_PEND, 32'h1, pwm_pkg::RESP_OKAY);
    wr(pwm_pkg::OFF_CTRL, 32'h2c, pwm_pkg::RESP_OKAY);
    wait_level(1'b0);
    wait_level(1'b1);
    wr(pwm_pkg::OFF_CTRL, 32'h0, pwm_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    count_high(32, hi);
    check_val(hi, 32'd0);
    $display("test extremes done");
    end_of_test();
  end
endmodule // tb
